// ==== rtl/rbc_top.sv ====
// reset qualification, start-up loader, memory steering and bus width
//
// Summary of operation
// - reset pin low sixteen state times while running resets chip
// - reset release restarts clock pin, ten-state start-up
// - start-up clears status word, loads config bytes
// - start-up ends with jump to start address
// - rising interrupt pin vectors through fixed location
// - access select steers upper program range on-chip
// - access select latched at reset, not live
// - static multiplier select: bypass or times four
// - both width bits set: pin sizes cycle
// - single width bit fixes all cycles width
// - width pin is general I/O when unused
`timescale 1ns/10ps
module rbc_top
  import rbc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // board pins
  input wire logic ext_reset_n_i,
  input wire logic nmi_i,
  input wire logic external_access_select_n_i,
  input wire logic crystal_multiplier_select_i,
  // width pin, shared with general port use
  input wire logic general_port_io_i,
  output logic general_port_io_o,
  output logic general_port_io_oe_o,
  input wire logic gpio_out_i,
  input wire logic gpio_oe_i,
  output logic gpio_in_o,
  // configuration fetch port
  output logic boot_rd_o,
  output logic [ADDR_W-1:0] boot_addr_o,
  input wire logic [7:0] boot_data_i,
  // core control
  output logic core_reset_o,
  output logic psw_clear_o,
  output logic [15:0] processor_status_word_o,
  output logic jump_o,
  output logic [ADDR_W-1:0] jump_addr_o,
  output logic nmi_take_o,
  output rbc_cfg_t chip_config_bytes_o,
  // clocking
  output logic clock_output_pin_o,
  output logic [2:0] clk_mult_o,
  // bus cycle steering
  input wire rbc_cyc_t bus_cyc_i,
  output rbc_route_t route_o,
  output logic width_illegal_o
);

  typedef enum logic [1:0] {
    ST_HOLD,
    ST_BOOT,
    ST_RUN
  } rbc_state_t;

  rbc_state_t state;
  logic [CNT_W-1:0] low_cnt;
  logic [CNT_W-1:0] boot_cnt;
  logic [CNT_W-1:0] phase;
  logic rst_pin;
  logic nmi_pin;
  logic sel_pin;
  logic pll_pin;
  logic wpin;
  logic nmi_prev;
  logic sel_latched;
  logic rd_pend;
  logic [1:0] rd_sel;
  rbc_cfg_t cfg;
  rbc_wmode_t wmode;
  logic wide;
  logic route_pend;
  logic route_onchip;

  localparam logic [CNT_W-1:0] RST_MIN_LAST = CNT_W'(RST_MIN_CYC - 1);
  localparam logic [CNT_W-1:0] BOOT_LAST = CNT_W'(BOOT_CYC - 1);
  localparam logic [CNT_W-1:0] PHASE_LAST = CNT_W'(STATE_CYC - 1);
  localparam logic [CNT_W-1:0] PHASE_HALF = CNT_W'(STATE_CYC / 2);

  // all pins come from outside the clock domain
  rbc_sync #(.W(5)) u_sync (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .async_i({ext_reset_n_i, nmi_i, external_access_select_n_i,
              crystal_multiplier_select_i, general_port_io_i}),
    .sync_o({rst_pin, nmi_pin, sel_pin, pll_pin, wpin})
  );

  // reset pin qualification and start-up sequencing; a short low
  // glitch on the pin is ignored so noise cannot restart the chip
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_HOLD;
      low_cnt <= '0;
      boot_cnt <= '0;
    end else begin
      unique case (state)
        ST_RUN: begin
          if (rst_pin) begin
            low_cnt <= '0;
          end else if (low_cnt == RST_MIN_LAST) begin
            state <= ST_HOLD;
            low_cnt <= '0;
          end else begin
            low_cnt <= low_cnt + 1'b1;
          end
        end
        ST_HOLD: begin
          boot_cnt <= '0;
          if (rst_pin) begin
            state <= ST_BOOT;
          end
        end
        ST_BOOT: begin
          if (boot_cnt == BOOT_LAST) begin
            state <= ST_RUN;
          end else begin
            boot_cnt <= boot_cnt + 1'b1;
          end
        end
      endcase
    end
  end

  // core held in reset until the start-up sequence is over
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_reset_o <= 1'b1;
    end else begin
      core_reset_o <= (state != ST_RUN);
    end
  end

  // clock pin: one period per state time, phase restarts on release
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      phase <= '0;
      clock_output_pin_o <= 1'b0;
    end else if (state == ST_HOLD) begin
      phase <= '0;
      clock_output_pin_o <= 1'b0;
    end else begin
      phase <= (phase == PHASE_LAST) ? '0 : phase + 1'b1;
      clock_output_pin_o <= (phase < PHASE_HALF);
    end
  end

  // straps are caught while reset is held, never under async reset
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sel_latched <= 1'b0;
      clk_mult_o <= PLL_BYPASS;
    end else if (state == ST_HOLD) begin
      sel_latched <= sel_pin;
      clk_mult_o <= pll_pin ? PLL_MULT : PLL_BYPASS;
    end
  end

  // status word cleared at the first start-up cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      psw_clear_o <= 1'b0;
      processor_status_word_o <= PSW_RST;
    end else begin
      psw_clear_o <= (state == ST_BOOT) && (boot_cnt == PSW_CLR_AT);
      if ((state == ST_BOOT) && (boot_cnt == PSW_CLR_AT)) begin
        processor_status_word_o <= PSW_RST;
      end
    end
  end

  // configuration fetches: read strobe one cycle, data the next;
  // the third byte is fetched only when the second enables it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      boot_rd_o <= 1'b0;
      boot_addr_o <= '0;
      rd_sel <= 2'h0;
    end else begin
      boot_rd_o <= 1'b0;
      if (state == ST_BOOT) begin
        if (boot_cnt == RD0_AT) begin
          boot_rd_o <= 1'b1;
          boot_addr_o <= CFG_BYTE0_ADDR;
          rd_sel <= 2'h0;
        end else if (boot_cnt == RD1_AT) begin
          boot_rd_o <= 1'b1;
          boot_addr_o <= CFG_BYTE1_ADDR;
          rd_sel <= 2'h1;
        end else if (boot_cnt == RD2_AT &&
                     cfg.config_register_1[CFG1_BYTE2_EN_BIT]) begin
          boot_rd_o <= 1'b1;
          boot_addr_o <= CFG_BYTE2_ADDR;
          rd_sel <= 2'h2;
        end
      end
    end
  end

  // capture returned byte into the selected configuration register;
  // a pin reset returns every byte to its erased value, so a third
  // byte from an earlier start-up cannot survive into a later one
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rd_pend <= 1'b0;
      cfg <= {CFG_BYTE_RST, CFG_BYTE_RST, CFG_BYTE_RST};
    end else if (state == ST_HOLD) begin
      rd_pend <= 1'b0;
      cfg <= {CFG_BYTE_RST, CFG_BYTE_RST, CFG_BYTE_RST};
    end else begin
      rd_pend <= boot_rd_o;
      if (rd_pend) begin
        unique case (rd_sel)
          2'h0: cfg.config_register_0 <= boot_data_i;
          2'h1: cfg.config_register_1 <= boot_data_i;
          2'h2: cfg.config_register_2 <= boot_data_i;
          default: cfg.config_register_2 <= cfg.config_register_2;
        endcase
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      chip_config_bytes_o <= {CFG_BYTE_RST, CFG_BYTE_RST, CFG_BYTE_RST};
    end else begin
      chip_config_bytes_o <= cfg;
    end
  end

  // jump to the start address on the last start-up cycle
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      jump_o <= 1'b0;
      jump_addr_o <= START_ADDR;
    end else begin
      jump_o <= 1'b0;
      if (state == ST_BOOT && boot_cnt == BOOT_LAST) begin
        jump_o <= 1'b1;
        jump_addr_o <= START_ADDR;
      end else if (state == ST_RUN && nmi_pin && !nmi_prev) begin
        jump_addr_o <= NMI_VEC_ADDR;
      end
    end
  end

  // rising edge on the interrupt pin, taken only while running;
  // an edge during reset or start-up is dropped on purpose
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      nmi_prev <= 1'b0;
      nmi_take_o <= 1'b0;
    end else begin
      nmi_prev <= nmi_pin;
      nmi_take_o <= (state == ST_RUN) && nmi_pin && !nmi_prev;
    end
  end

  // width decision held per cycle inside the width module
  rbc_width u_width (
    .sys_clk_i(sys_clk_i),
    .arst_n_i(arst_n_i),
    .cfg_i(cfg),
    .cyc_start_i(bus_cyc_i.start),
    .width_pin_i(wpin),
    .mode_o(wmode),
    .wide_o(wide)
  );

  // steering of the upper program range by the latched select
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route_pend <= 1'b0;
      route_onchip <= 1'b0;
    end else begin
      route_pend <= bus_cyc_i.start;
      if (bus_cyc_i.start) begin
        route_onchip <= sel_latched &&
                        bus_cyc_i.addr >= ONCHIP_LO &&
                        bus_cyc_i.addr <= ONCHIP_HI;
      end
    end
  end

  // route result registered one cycle after the width is held
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      route_o <= '0;
      width_illegal_o <= 1'b0;
    end else begin
      route_o.valid <= route_pend;
      if (route_pend) begin
        route_o.onchip <= route_onchip;
        route_o.wide <= wide;
      end
      width_illegal_o <= (wmode == RBC_W_ILLEGAL);
    end
  end

  // width pin free for general use unless dynamic sizing needs it
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      general_port_io_o <= 1'b0;
      general_port_io_oe_o <= 1'b0;
      gpio_in_o <= 1'b0;
    end else begin
      general_port_io_o <= gpio_out_i;
      general_port_io_oe_o <= gpio_oe_i &&
                              (wmode != RBC_W_DYNAMIC);
      gpio_in_o <= wpin;
    end
  end

endmodule

// ==== include/rbc_pkg.sv ====
// package: constants and carriers for reset, boot and bus-width config
package rbc_pkg;

  // system clock rate and the length of one state time
  localparam int unsigned SYS_CLK_HZ = 50_000_000;
  localparam int unsigned STATE_CYC = 2;

  // times in state times, counts in system clocks
  localparam int unsigned RST_MIN_ST = 16;
  localparam int unsigned BOOT_ST = 10;
  localparam int unsigned RST_MIN_CYC = RST_MIN_ST * STATE_CYC;
  localparam int unsigned BOOT_CYC = BOOT_ST * STATE_CYC;
  localparam int unsigned CNT_W = 6;

  // boot cycle offsets for the status clear and the three configuration fetches
  localparam logic [CNT_W-1:0] PSW_CLR_AT = 6'h00;
  localparam logic [CNT_W-1:0] RD0_AT = 6'h02;
  localparam logic [CNT_W-1:0] RD1_AT = 6'h06;
  localparam logic [CNT_W-1:0] RD2_AT = 6'h0A;

  // addresses
  localparam int unsigned ADDR_W = 24;
  localparam logic [ADDR_W-1:0] CFG_BYTE0_ADDR = 24'h002018;
  localparam logic [ADDR_W-1:0] CFG_BYTE1_ADDR = 24'h00201A;
  localparam logic [ADDR_W-1:0] CFG_BYTE2_ADDR = 24'h00201C;
  localparam logic [ADDR_W-1:0] START_ADDR = 24'h002080;
  localparam logic [ADDR_W-1:0] NMI_VEC_ADDR = 24'h00203E;
  localparam logic [ADDR_W-1:0] ONCHIP_LO = 24'hFF2000;
  localparam logic [ADDR_W-1:0] ONCHIP_HI = 24'hFFFFFF;

  // configuration field positions and reset values
  localparam int unsigned CFG0_WIDTH_BIT = 1;
  localparam int unsigned CFG1_WIDTH_BIT = 2;
  localparam int unsigned CFG1_BYTE2_EN_BIT = 0;
  localparam logic [7:0] CFG_BYTE_RST = 8'hFF;
  localparam logic [15:0] PSW_RST = 16'h0000;

  // crystal multiplier factor when the multiplier is selected, and when bypassed
  localparam logic [2:0] PLL_MULT = 3'h4;
  localparam logic [2:0] PLL_BYPASS = 3'h1;

  // bus width modes
  typedef enum logic [1:0] {
    RBC_W_ILLEGAL,
    RBC_W_FIXED8,
    RBC_W_FIXED16,
    RBC_W_DYNAMIC
  } rbc_wmode_t;

  // configuration bytes loaded at start-up
  typedef struct packed {
    logic [7:0] config_register_0;
    logic [7:0] config_register_1;
    logic [7:0] config_register_2;
  } rbc_cfg_t;

  // one external bus cycle as seen by the steering logic
  typedef struct packed {
    logic start;
    logic [ADDR_W-1:0] addr;
  } rbc_cyc_t;

  // result for one bus cycle
  typedef struct packed {
    logic valid;
    logic onchip;
    logic wide;
  } rbc_route_t;

endpackage

// ==== rtl/rbc_sync.sv ====
// two-flop synchroniser for asynchronous pin levels
`timescale 1ns/10ps
module rbc_sync #(
  parameter int unsigned W = 1
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // levels
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] sync_o
);

  logic [W-1:0] meta;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta <= '0;
      sync_o <= '0;
    end else begin
      meta <= async_i;
      sync_o <= meta;
    end
  end

endmodule

// ==== rtl/rbc_width.sv ====
// per-cycle bus width decision and the width mode used for pin sharing
`timescale 1ns/10ps
module rbc_width
  import rbc_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  // configuration and cycle
  input wire rbc_cfg_t cfg_i,
  input wire logic cyc_start_i,
  input wire logic width_pin_i,
  // results
  output rbc_wmode_t mode_o,
  output logic wide_o
);

  // decode of the two width bits, used for mode and for width
  function automatic rbc_wmode_t decode(input rbc_cfg_t c);
    unique case ({c.config_register_0[CFG0_WIDTH_BIT],
                  c.config_register_1[CFG1_WIDTH_BIT]})
      2'b11: decode = RBC_W_DYNAMIC;
      2'b01: decode = RBC_W_FIXED8;
      2'b10: decode = RBC_W_FIXED16;
      default: decode = RBC_W_ILLEGAL;
    endcase
  endfunction

  rbc_wmode_t mode;
  assign mode = decode(cfg_i);
  assign mode_o = mode;

  // width is fixed at cycle start and held for the whole cycle;
  // the illegal pair falls back to 8-bit as the safer guess
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wide_o <= 1'b0;
    end else if (cyc_start_i) begin
      unique case (mode)
        RBC_W_DYNAMIC: wide_o <= width_pin_i;
        RBC_W_FIXED16: wide_o <= 1'b1;
        RBC_W_FIXED8: wide_o <= 1'b0;
        RBC_W_ILLEGAL: wide_o <= 1'b0;
      endcase
    end
  end

endmodule

// ==== verification/rbc_checker.sv ====
// checker: port-level properties of the reset, boot and bus width block
`timescale 1ns/10ps
module rbc_checker
  import rbc_pkg::*;
(
  // clock, reset and straps
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic ext_reset_n_i,
  input wire logic crystal_multiplier_select_i,
  // boot and core side
  input wire logic boot_rd_o,
  input wire logic [ADDR_W-1:0] boot_addr_o,
  input wire logic core_reset_o,
  input wire logic psw_clear_o,
  input wire logic [15:0] processor_status_word_o,
  input wire logic jump_o,
  input wire logic [ADDR_W-1:0] jump_addr_o,
  input wire logic nmi_take_o,
  input wire rbc_cfg_t chip_config_bytes_o,
  input wire logic clock_output_pin_o,
  input wire logic [2:0] clk_mult_o,
  input wire logic general_port_io_oe_o,
  // bus side
  input wire rbc_cyc_t bus_cyc_i,
  input wire rbc_route_t route_o,
  input wire logic width_illegal_o
);
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);
  logic [5:0] low_cnt;
  wire logic dyn = chip_config_bytes_o.config_register_0[CFG0_WIDTH_BIT] &
    chip_config_bytes_o.config_register_1[CFG1_WIDTH_BIT];
  // length of the present low spell on the reset pin, saturating
  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i)
      low_cnt <= 6'h00;
    else if (ext_reset_n_i)
      low_cnt <= 6'h00;
    else if (low_cnt != 6'h3F)
      low_cnt <= low_cnt + 6'h01;
  end
  property p_hold; low_cnt == 6'h3C |-> core_reset_o; endproperty
  a_hold: assert property (p_hold) else $error("long reset not taken");
  property p_clk_run;
    !core_reset_o && !$past(core_reset_o) |->
      clock_output_pin_o != $past(clock_output_pin_o);
  endproperty
  a_clk_run: assert property (p_clk_run) else $error("clock pin stuck");
  // status clear at count 0, jump at the last count of the start-up
  property p_boot_len; psw_clear_o |-> ##19 jump_o; endproperty
  a_boot_len: assert property (p_boot_len) else $error("boot length");
  property p_fetch0;
    psw_clear_o |-> ##[2:4] (boot_rd_o && boot_addr_o == CFG_BYTE0_ADDR);
  endproperty
  a_fetch0: assert property (p_fetch0) else $error("first fetch");
  property p_fetch1;
    boot_rd_o && boot_addr_o == CFG_BYTE0_ADDR |->
      ##4 (boot_rd_o && boot_addr_o == CFG_BYTE1_ADDR);
  endproperty
  a_fetch1: assert property (p_fetch1) else $error("second fetch");
  property p_psw; psw_clear_o |=> processor_status_word_o == PSW_RST; endproperty
  a_psw: assert property (p_psw) else $error("status not clear");
  property p_jump;
    jump_o |-> jump_addr_o == START_ADDR ##1 !core_reset_o;
  endproperty
  a_jump: assert property (p_jump) else $error("bad start jump");
  property p_nmi;
    nmi_take_o |-> jump_addr_o == NMI_VEC_ADDR && !core_reset_o;
  endproperty
  a_nmi: assert property (p_nmi) else $error("bad interrupt vector");
  property p_onchip;
    route_o.valid && route_o.onchip |-> $past(bus_cyc_i.addr, 2) >= ONCHIP_LO;
  endproperty
  a_onchip: assert property (p_onchip) else $error("on-chip range");
  property p_mult;
    !core_reset_o |->
      clk_mult_o == (crystal_multiplier_select_i ? PLL_MULT : PLL_BYPASS);
  endproperty
  a_mult: assert property (p_mult) else $error("multiplier select");
  property p_fixed;
    route_o.valid && !dyn && !width_illegal_o |->
      route_o.wide == chip_config_bytes_o.config_register_0[CFG0_WIDTH_BIT];
  endproperty
  a_fixed: assert property (p_fixed) else $error("fixed width");
  property p_illegal; route_o.valid && width_illegal_o |-> !route_o.wide; endproperty
  a_illegal: assert property (p_illegal) else $error("illegal width");
  property p_oe; dyn && $past(dyn) && !core_reset_o |-> !general_port_io_oe_o; endproperty
  a_oe: assert property (p_oe) else $error("width pin driven");
  property p_route; bus_cyc_i.start |-> ##2 route_o.valid; endproperty
  a_route: assert property (p_route) else $error("route late");
  // main scenarios reached
  c_jump: cover property (jump_o);
  c_nmi: cover property (nmi_take_o);
  c_wide: cover property (route_o.valid && route_o.wide && dyn);
  c_illegal: cover property (route_o.valid && width_illegal_o);
endmodule

// ==== verification/rbc_mem_model.sv ====
// model of the external memory answering configuration fetches
`timescale 1ns/10ps
module rbc_mem_model
  import rbc_pkg::*;
(
  // clock
  input wire logic sys_clk_i,
  // fetch port
  input wire logic boot_rd_i,
  input wire logic [ADDR_W-1:0] boot_addr_i,
  input wire rbc_cfg_t image_i,
  output logic [7:0] boot_data_o
);
  logic [7:0] held = 8'h5A;
  logic [1:0] age = 2'h3;
  // byte stands only around the sampling edge; a late sample sees garbage
  always @(posedge sys_clk_i) begin
    if (boot_rd_i) begin
      age <= 2'h0;
      case (boot_addr_i)
        CFG_BYTE0_ADDR: held <= image_i.config_register_0;
        CFG_BYTE1_ADDR: held <= image_i.config_register_1;
        CFG_BYTE2_ADDR: held <= image_i.config_register_2;
        default: held <= 8'hA5;
      endcase
    end else if (age != 2'h3)
      age <= age + 2'h1;
  end
  assign boot_data_o = (age < 2'h2) ? held : ~held;
endmodule

// ==== verification/rbc_top_tb_top.sv ====
// self-checking bench for the reset, boot and bus width block
`timescale 1ns/10ps
module rbc_top_tb_top
  import rbc_pkg::*;
;
  logic sys_clk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic ext_reset_n_i = 1'b0;
  logic nmi_i = 1'b0;
  logic sel = 1'b0;
  logic sel_l = 1'b0;
  logic mult = 1'b0;
  logic pin_drv = 1'b0;
  logic gpio_out = 1'b0;
  logic gpio_oe = 1'b0;
  logic io_o, io_oe, gpio_in, boot_rd, core_reset, psw_clear, jump;
  logic nmi_take, clk_pin, illegal;
  logic [7:0] boot_data;
  logic [15:0] processor_status_word;
  logic [2:0] clk_mult;
  logic [ADDR_W-1:0] boot_addr, jump_addr;
  rbc_cfg_t image = '0;
  rbc_cfg_t cfg;
  rbc_cyc_t cyc = '0;
  rbc_route_t route;
  wire logic pin_lvl;
  int mismatches = 0;
  int checked = 0;
  logic [31:0] rng = 32'h00000050;
  // the width pin wire: the block wins while it enables its driver
  assign pin_lvl = io_oe ? io_o : pin_drv;
  always #10 sys_clk_i = ~sys_clk_i;
  rbc_top uut (
    .sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i),
    .ext_reset_n_i(ext_reset_n_i), .nmi_i(nmi_i),
    .external_access_select_n_i(sel), .crystal_multiplier_select_i(mult),
    .general_port_io_i(pin_lvl), .general_port_io_o(io_o),
    .general_port_io_oe_o(io_oe), .gpio_out_i(gpio_out),
    .gpio_oe_i(gpio_oe), .gpio_in_o(gpio_in), .boot_rd_o(boot_rd),
    .boot_addr_o(boot_addr), .boot_data_i(boot_data),
    .core_reset_o(core_reset), .psw_clear_o(psw_clear),
    .processor_status_word_o(processor_status_word), .jump_o(jump), .jump_addr_o(jump_addr),
    .nmi_take_o(nmi_take), .chip_config_bytes_o(cfg),
    .clock_output_pin_o(clk_pin), .clk_mult_o(clk_mult),
    .bus_cyc_i(cyc), .route_o(route), .width_illegal_o(illegal)
  );
  rbc_mem_model mem (.sys_clk_i(sys_clk_i), .boot_rd_i(boot_rd),
    .boot_addr_i(boot_addr), .image_i(image), .boot_data_o(boot_data));
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    if (mismatches == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic give_up();
    mismatches++;
    complete_run();
  endtask
  // long pin reset, new straps and image, then the whole start-up
  task automatic boot(input int i);
    logic [ADDR_W-1:0] q[$];
    logic en;
    logic seen;
    logic [31:0] r;
    int n;
    ext_reset_n_i = 1'b0;
    repeat (40) @(negedge sys_clk_i);
    chk(core_reset, 1'b1);
    chk(clk_pin, 1'b0);
    en = i[1] ^ i[0];
    r = xs();
    image = r[23:0];
    image.config_register_0[CFG0_WIDTH_BIT] = i[1];
    image.config_register_1[CFG1_WIDTH_BIT] = i[0];
    image.config_register_1[CFG1_BYTE2_EN_BIT] = en;
    sel = (i != 1);
    sel_l = sel;
    mult = i[1];
    q = {CFG_BYTE0_ADDR, CFG_BYTE1_ADDR};
    if (en)
      q.push_back(CFG_BYTE2_ADDR);
    seen = 1'b0;
    repeat (24) @(negedge sys_clk_i);
    ext_reset_n_i = 1'b1;
    for (n = 0; n < 60 && !jump; n++) begin
      @(negedge sys_clk_i);
      if (psw_clear)
        seen = 1'b1;
      if (boot_rd)
        chk(boot_addr, q.size() ? q.pop_front() : '1);
    end
    if (n == 60)
      give_up();
    // two sync clocks and the hold exit come before the start-up count
    chk(n, BOOT_CYC + 3);
    chk(jump_addr, START_ADDR);
    chk(q.size(), 0);
    chk(seen, 1'b1);
    chk(processor_status_word, PSW_RST);
    @(negedge sys_clk_i);
    chk(core_reset, 1'b0);
    chk(cfg, {image.config_register_0, image.config_register_1,
      en ? image.config_register_2 : CFG_BYTE_RST});
    chk(clk_mult, mult ? 3'h4 : 3'h1);
    chk(illegal, i == 0);
  endtask
  // one external cycle; the width pin moves right after the start
  task automatic bus(input int i, input logic [ADDR_W-1:0] a);
    logic w;
    int n;
    w = ^xs();
    pin_drv = w;
    repeat (3) @(negedge sys_clk_i);
    chk(gpio_in, w);
    cyc = {1'b1, a};
    @(negedge sys_clk_i);
    cyc.start = 1'b0;
    pin_drv = !w;
    for (n = 0; n < 4 && !route.valid; n++)
      @(negedge sys_clk_i);
    if (n == 4)
      give_up();
    chk(route.onchip, sel_l && a >= ONCHIP_LO);
    chk(route.wide, i == 3 ? w : i == 2);
  endtask
  // main sequence: every width mode, interrupt, pin sharing, steering
  initial begin
    logic [31:0] r;
    int n;
    repeat (5) @(negedge sys_clk_i);
    arst_n_i = 1'b1;
    for (int i = 0; i < 4; i++) begin
      boot(i);
      gpio_oe = 1'b1;
      gpio_out = rng[3];
      repeat (5) @(negedge sys_clk_i);
      chk(io_oe, i != 3);
      if (i != 3)
        chk(gpio_in, gpio_out);
      gpio_oe = 1'b0;
      nmi_i = 1'b1;
      for (n = 0; n < 6 && !nmi_take; n++)
        @(negedge sys_clk_i);
      if (n == 6)
        give_up();
      chk(jump_addr, NMI_VEC_ADDR);
      nmi_i = 1'b0;
      if (i == 0) begin
        // a short low spell on the reset pin must be ignored
        ext_reset_n_i = 1'b0;
        repeat (10) @(negedge sys_clk_i);
        ext_reset_n_i = 1'b1;
        repeat (40) @(negedge sys_clk_i);
        chk(core_reset, 1'b0);
      end
      sel = !sel;
      for (int k = 0; k < 10; k++) begin
        r = xs();
        bus(i, k == 0 ? ONCHIP_LO - 1 : k == 1 ? ONCHIP_LO :
          k == 2 ? ONCHIP_HI : k[0] ? {8'hFF, r[15:0]} : r[23:0]);
      end
    end
    complete_run();
  end
endmodule
bind rbc_top rbc_checker chk_u (.sys_clk_i, .arst_n_i, .ext_reset_n_i,
  .crystal_multiplier_select_i, .boot_rd_o, .boot_addr_o, .core_reset_o,
  .psw_clear_o, .processor_status_word_o, .jump_o, .jump_addr_o,
  .nmi_take_o, .chip_config_bytes_o, .clock_output_pin_o, .clk_mult_o,
  .general_port_io_oe_o, .bus_cyc_i, .route_o, .width_illegal_o);
